// ===== hdl/amf_pkg.sv
// amf_pkg: constants and types for the operand addressing unit
// assumes an 8-bit core with a 16-bit byte-wide memory bus
package amf_pkg;
    typedef enum logic [4:0] {
        AMF_INH      = 5'h00,
        AMF_IMM      = 5'h01,
        AMF_DIR_S    = 5'h02,
        AMF_DIR_L    = 5'h03,
        AMF_IDX_0    = 5'h04,
        AMF_IDX_S    = 5'h05,
        AMF_IDX_L    = 5'h06,
        AMF_IND_S    = 5'h07,
        AMF_IND_L    = 5'h08,
        AMF_INDX_S   = 5'h09,
        AMF_INDX_L   = 5'h0A,
        AMF_REL_D    = 5'h0B,
        AMF_REL_I    = 5'h0C,
        AMF_BIT_D    = 5'h0D,
        AMF_BIT_I    = 5'h0E,
        AMF_BITR_D   = 5'h0F,
        AMF_BITR_I   = 5'h10
    } amf_mode_t;

    typedef enum logic [3:0] {
        AMF_CL_INHERENT = 4'h0,
        AMF_CL_ALU      = 4'h1,
        AMF_CL_RMW      = 4'h2,
        AMF_CL_BIT      = 4'h3,
        AMF_CL_BRANCH   = 4'h4,
        AMF_CL_JUMP     = 4'h5
    } amf_class_t;

    // gray order along fetch path: idle, op1, op2, ptr hi, ptr lo, done
    typedef enum logic [2:0] {
        AMF_ST_IDLE = 3'b000,
        AMF_ST_OP1  = 3'b001,
        AMF_ST_OP2  = 3'b011,
        AMF_ST_PTR1 = 3'b010,
        AMF_ST_PTR2 = 3'b110,
        AMF_ST_DONE = 3'b111
    } amf_state_t;

    localparam logic [15:0] AMF_ADDR_RST = 16'h0000;
    localparam logic [7:0]  AMF_BYTE_RST = 8'h00;
    localparam logic [7:0]  AMF_PAGE0_HI = 8'h00;
    localparam logic [1:0]  AMF_LEN_ZERO = 2'h0;
endpackage

// ===== hdl/amf_operand_fetch.sv
// amf_operand_fetch: operand byte fetch and effective address forming
// assumes a memory with one-cycle read data, valid when i_mem_rdy is high
`timescale 1ns/10ps

// How it works
// - inherent instructions fetch no operand byte at all
// - immediate fetches one byte and returns it as the operand value
// - short direct fetches one address byte, address in page zero
// - long direct fetches two address bytes, high byte first
// - indexed address is unsigned sum of index and offset
// - no-offset indexed fetches nothing; Y form adds one byte
// - short indexed adds byte offset to index, up to 1FE
// - long indexed adds word offset to index, full space
// - short indirect reads byte pointer from page zero
// - long indirect reads word pointer from page zero
// - indirect indexed adds index to pointer read from page zero
// - short form reaches 1FE, long form 64 Kbyte, one byte after opcode
// - relative target is next pc plus signed byte offset
// - long forms reach full space, short forms page zero or, when indexed, up to 1FE
// - read-modify-write class refuses long addressing forms
// - inherent class carries the register and control operations
// - immediate accepted only for alu class
// - alu class accepted in long and short memory forms
// - relative indirect reads offset from page zero
module amf_operand_fetch import amf_pkg::*; (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire amf_mode_t   i_mode,
    input  wire amf_class_t  i_class,
    input  wire logic        i_use_y,
    input  wire logic [2:0]  i_bit_sel,
    input  wire logic [7:0]  i_x,
    input  wire logic [7:0]  i_y,
    input  wire logic [15:0] i_pc,
    input  wire logic [7:0]  i_mem_rdata,
    input  wire logic        i_mem_rdy,
    output logic             o_busy,
    output logic             o_mem_req,
    output logic [15:0]      o_mem_addr,
    output logic             o_done,
    output logic             o_illegal,
    output logic [15:0]      o_ea,
    output logic [7:0]       o_imm,
    output logic             o_imm_valid,
    output logic [7:0]       o_bit_mask,
    output logic [1:0]       o_len
);
    amf_state_t  st_q, st_d;
    amf_mode_t   mode_q, mode_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] ea_q, ea_d;
    logic [15:0] tmp_q, tmp_d;
    logic [7:0]  imm_q, imm_d;
    logic [7:0]  idx_q, idx_d;
    logic [7:0]  mask_q, mask_d;
    logic [1:0]  len_q, len_d;
    logic        ill_q, ill_d;
    logic        immv_q, immv_d;
    logic        long_op, short_ok, two_op, is_ptr, is_idx;
    logic [7:0]  op_byte;

    // mode properties, decoded from the latched mode
    always_comb begin
        long_op = (mode_q == AMF_DIR_L) || (mode_q == AMF_IDX_L);
        two_op  = long_op;
        is_ptr  = (mode_q == AMF_IND_S) || (mode_q == AMF_IND_L) || (mode_q == AMF_INDX_S) ||
                  (mode_q == AMF_INDX_L) || (mode_q == AMF_REL_I) || (mode_q == AMF_BIT_I) ||
                  (mode_q == AMF_BITR_I);
        is_idx  = (mode_q == AMF_IDX_S) || (mode_q == AMF_IDX_L) ||
                  (mode_q == AMF_INDX_S) || (mode_q == AMF_INDX_L);
        op_byte = i_mem_rdata;
    end

    // class versus mode legality, judged at start
    always_comb begin
        short_ok = 1'b1;
        case (i_class)
            AMF_CL_INHERENT: short_ok = (i_mode == AMF_INH);
            AMF_CL_ALU:      short_ok = (i_mode != AMF_INH) && (i_mode < AMF_REL_D);
            AMF_CL_RMW:      short_ok = (i_mode == AMF_DIR_S) || (i_mode == AMF_IDX_0) ||
                                        (i_mode == AMF_IDX_S) || (i_mode == AMF_IND_S) ||
                                        (i_mode == AMF_INDX_S);
            AMF_CL_BIT:      short_ok = (i_mode >= AMF_BIT_D);
            AMF_CL_BRANCH:   short_ok = (i_mode == AMF_REL_D) || (i_mode == AMF_REL_I);
            AMF_CL_JUMP:     short_ok = (i_mode >= AMF_DIR_S) && (i_mode <= AMF_INDX_L);
            default:         short_ok = 1'b0;
        endcase
    end

    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        pc_d   = pc_q;
        ea_d   = ea_q;
        tmp_d  = tmp_q;
        imm_d  = imm_q;
        idx_d  = idx_q;
        mask_d = mask_q;
        len_d  = len_q;
        ill_d  = ill_q;
        immv_d = immv_q;
        case (st_q)
            AMF_ST_IDLE: begin
                if (i_start) begin
                    mode_d = i_mode;
                    pc_d   = i_pc;
                    idx_d  = i_use_y ? i_y : i_x;
                    mask_d = 8'h01 << i_bit_sel;
                    ill_d  = !short_ok;
                    immv_d = 1'b0;
                    ea_d   = AMF_ADDR_RST;
                    // Y prefix costs one byte on every indexed and indirect form, AMF_IDX_0 through AMF_INDX_L
                    len_d  = (i_use_y && (i_mode >= AMF_IDX_0) && (i_mode <= AMF_INDX_L)) ? 2'd1 : AMF_LEN_ZERO;
                    if (!short_ok || i_mode == AMF_INH)
                        st_d = AMF_ST_DONE;
                    else if (i_mode == AMF_IDX_0) begin
                        ea_d = {AMF_PAGE0_HI, (i_use_y ? i_y : i_x)};
                        st_d = AMF_ST_DONE;
                    end else
                        st_d = AMF_ST_OP1;
                end
            end
            AMF_ST_OP1: begin
                if (i_mem_rdy) begin
                    pc_d  = pc_q + 16'h0001;
                    len_d = len_q + 2'd1;
                    case (mode_q)
                        AMF_IMM: begin
                            imm_d  = op_byte;
                            immv_d = 1'b1;
                            st_d   = AMF_ST_DONE;
                        end
                        AMF_DIR_S, AMF_BIT_D: begin
                            ea_d = {AMF_PAGE0_HI, op_byte};
                            st_d = AMF_ST_DONE;
                        end
                        AMF_BITR_D: begin
                            ea_d = {AMF_PAGE0_HI, op_byte};
                            st_d = AMF_ST_DONE;
                        end
                        AMF_IDX_S: begin
                            ea_d = {8'h00, op_byte} + {8'h00, idx_q};
                            st_d = AMF_ST_DONE;
                        end
                        AMF_REL_D: begin
                            // pc_q + 1 is the next instruction address
                            ea_d = (pc_q + 16'h0001) + {{8{op_byte[7]}}, op_byte};
                            st_d = AMF_ST_DONE;
                        end
                        default: begin
                            tmp_d = {AMF_PAGE0_HI, op_byte};
                            st_d  = two_op ? AMF_ST_OP2 : AMF_ST_PTR1;
                        end
                    endcase
                end
            end
            AMF_ST_OP2: begin
                if (i_mem_rdy) begin
                    pc_d  = pc_q + 16'h0001;
                    len_d = len_q + 2'd1;
                    if (is_idx)
                        ea_d = {tmp_q[7:0], op_byte} + {8'h00, idx_q};
                    else
                        ea_d = {tmp_q[7:0], op_byte};
                    st_d = AMF_ST_DONE;
                end
            end
            AMF_ST_PTR1: begin
                if (i_mem_rdy) begin
                    tmp_d = {AMF_PAGE0_HI, tmp_q[7:0] + 8'h01};
                    case (mode_q)
                        AMF_IND_L, AMF_INDX_L: begin
                            imm_d = op_byte;
                            st_d  = AMF_ST_PTR2;
                        end
                        AMF_INDX_S: begin
                            ea_d = {8'h00, op_byte} + {8'h00, idx_q};
                            st_d = AMF_ST_DONE;
                        end
                        AMF_REL_I: begin
                            ea_d = pc_q + {{8{op_byte[7]}}, op_byte};
                            st_d = AMF_ST_DONE;
                        end
                        default: begin
                            ea_d = {AMF_PAGE0_HI, op_byte};
                            st_d = AMF_ST_DONE;
                        end
                    endcase
                end
            end
            AMF_ST_PTR2: begin
                if (i_mem_rdy) begin
                    if (mode_q == AMF_INDX_L)
                        ea_d = {imm_q, op_byte} + {8'h00, idx_q};
                    else
                        ea_d = {imm_q, op_byte};
                    st_d = AMF_ST_DONE;
                end
            end
            AMF_ST_DONE: st_d = AMF_ST_IDLE;
            default:     st_d = AMF_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q   <= AMF_ST_IDLE;
            mode_q <= AMF_INH;
            pc_q   <= AMF_ADDR_RST;
            ea_q   <= AMF_ADDR_RST;
            tmp_q  <= AMF_ADDR_RST;
            imm_q  <= AMF_BYTE_RST;
            idx_q  <= AMF_BYTE_RST;
            mask_q <= AMF_BYTE_RST;
            len_q  <= AMF_LEN_ZERO;
            ill_q  <= 1'b0;
            immv_q <= 1'b0;
        end else if (i_ce) begin
            st_q   <= st_d;
            mode_q <= mode_d;
            pc_q   <= pc_d;
            ea_q   <= ea_d;
            tmp_q  <= tmp_d;
            imm_q  <= imm_d;
            idx_q  <= idx_d;
            mask_q <= mask_d;
            len_q  <= len_d;
            ill_q  <= ill_d;
            immv_q <= immv_d;
        end
    end

    // operand stream reads go to pc, pointer reads to page zero
    always_comb begin
        o_mem_req  = i_ce && ((st_q == AMF_ST_OP1) || (st_q == AMF_ST_OP2) ||
                              (st_q == AMF_ST_PTR1) || (st_q == AMF_ST_PTR2));
        o_mem_addr = (st_q == AMF_ST_PTR1 || st_q == AMF_ST_PTR2) ? tmp_q : pc_q;
        o_busy     = (st_q != AMF_ST_IDLE);
        o_done     = (st_q == AMF_ST_DONE);
    end

    assign o_illegal   = ill_q;
    assign o_ea        = ea_q;
    assign o_imm       = imm_q;
    assign o_imm_valid = immv_q;
    assign o_bit_mask  = mask_q;
    assign o_len       = len_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    inherent_no_fetch_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && i_mode == AMF_INH
        |=> o_done && !o_mem_req && o_len == 2'h0) else $error("inherent fetched a byte");
    imm_value_a: assert property (
        i_ce && st_q == AMF_ST_OP1 && mode_q == AMF_IMM && i_mem_rdy
        |=> o_imm == $past(i_mem_rdata) && o_imm_valid) else $error("immediate value wrong");
    short_dir_page_a: assert property (
        o_done && mode_q == AMF_DIR_S |-> o_ea[15:8] == 8'h00) else $error("short direct left page zero");
    long_dir_order_a: assert property (
        i_ce && st_q == AMF_ST_OP2 && mode_q == AMF_DIR_L && i_mem_rdy
        |=> o_ea == {$past(tmp_q[7:0]), $past(i_mem_rdata)}) else $error("long direct byte order wrong");
    idx_short_range_a: assert property (
        o_done && mode_q == AMF_IDX_S |-> o_ea <= 16'h01FE) else $error("short indexed beyond 1FE");
    idx_long_sum_a: assert property (
        i_ce && st_q == AMF_ST_OP2 && mode_q == AMF_IDX_L && i_mem_rdy
        |=> o_ea == {$past(tmp_q[7:0]), $past(i_mem_rdata)} + {8'h00, $past(idx_q)})
        else $error("long indexed sum wrong");
    // a refused mode leaves the address cleared, so only legal starts are judged
    noofs_idx_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && short_ok && i_mode == AMF_IDX_0 && !i_use_y
        |=> o_ea == {8'h00, $past(i_x)} && o_done) else $error("no offset index wrong");
    ptr_page0_a: assert property (
        st_q == AMF_ST_PTR1 |-> o_mem_addr[15:8] == 8'h00) else $error("pointer read off page zero");
    word_ptr_page0_a: assert property (
        st_q == AMF_ST_PTR2 |-> o_mem_addr[15:8] == 8'h00) else $error("pointer word left page zero");
    ind_idx_range_a: assert property (
        o_done && mode_q == AMF_INDX_S |-> o_ea <= 16'h01FE) else $error("short indirect indexed beyond 1FE");
    rel_target_a: assert property (
        i_ce && st_q == AMF_ST_OP1 && mode_q == AMF_REL_D && i_mem_rdy
        |=> o_ea == $past(pc_q) + 16'h0001 + {{8{$past(i_mem_rdata[7])}}, $past(i_mem_rdata)})
        else $error("relative target wrong");
    rel_ind_target_a: assert property (
        i_ce && st_q == AMF_ST_PTR1 && mode_q == AMF_REL_I && i_mem_rdy
        |=> o_ea == $past(pc_q) + {{8{$past(i_mem_rdata[7])}}, $past(i_mem_rdata)})
        else $error("relative indirect target wrong");
    rmw_long_refused_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && i_class == AMF_CL_RMW &&
        (i_mode == AMF_DIR_L || i_mode == AMF_IDX_L)
        |=> o_illegal && o_done) else $error("rmw long taken");
    inherent_class_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && i_class == AMF_CL_INHERENT && i_mode != AMF_INH
        |=> o_illegal && o_done) else $error("inherent class took an operand mode");
    imm_refused_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && i_mode == AMF_IMM && i_class != AMF_CL_ALU
        |=> o_illegal && o_done && !o_imm_valid) else $error("immediate taken outside alu class");
    alu_long_ok_a: assert property (
        i_ce && st_q == AMF_ST_IDLE && i_start && i_class == AMF_CL_ALU &&
        (i_mode == AMF_DIR_L || i_mode == AMF_IDX_L || i_mode == AMF_IND_L || i_mode == AMF_INDX_L)
        |=> !o_illegal && o_busy) else $error("alu long form refused");
    bit_mask_a: assert property (
        o_done |-> $onehot(o_bit_mask)) else $error("bit mask not one hot");

    long_dir_c: cover property (o_done && mode_q == AMF_DIR_L);
    ind_long_idx_c: cover property (o_done && mode_q == AMF_INDX_L);
    rel_ind_c: cover property (o_done && mode_q == AMF_REL_I);
    refused_c: cover property (o_done && o_illegal);
    slow_beat_c: cover property (o_mem_req && !i_mem_rdy);
endmodule

// ===== dv/amf_mem_model.sv
// amf_mem_model: byte-wide program and data memory facing the fetch unit
// assumes the unit holds address and request until rdy is high
`timescale 1ns/10ps
module amf_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_rdy,
    output logic [7:0]       o_rdata
);
    logic       wait_q;
    logic       wait_d;
    logic [7:0] last_q;
    logic [7:0] last_d;
    // slow mode answers every second requested cycle
    always_comb begin
        o_rdy   = i_req & (~i_slow | wait_q);
        o_rdata = o_rdy ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h3C) : ~last_q; // no stale byte when idle
        wait_d  = i_req & ~wait_q;
        last_d  = o_rdy ? o_rdata : last_q;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wait_q <= 1'b0;
            last_q <= 8'h00;
        end else begin
            wait_q <= wait_d;
            last_q <= last_d;
        end
    end
endmodule

// ===== dv/addressing_mode_operand_fetch_tb.sv
// addressing_mode_operand_fetch_tb: self-checking bench for amf_operand_fetch
// assumes amf_mem_model on the memory port, memory byte = lo ^ hi ^ 3C
`timescale 1ns/10ps
module addressing_mode_operand_fetch_tb;
    import amf_pkg::*;
    typedef struct {amf_mode_t m; amf_class_t c; logic y; logic [7:0] ix; logic [15:0] pc;
                    logic [1:0] len; int beats; logic ill;} amf_row_t;
    logic        clk, rstn, ce, start, use_y, slow;
    logic        mem_req, mem_rdy, busy, done, illegal, imm_valid;
    logic [2:0]  bit_sel;
    logic [7:0]  x, y, rdata, imm, mask;
    logic [15:0] pc, mem_addr, ea;
    logic [1:0]  len;
    amf_mode_t   mode;
    amf_class_t  cls;
    int          miscompares, checks_done, n;
    amf_row_t    rows [27] = '{
        '{AMF_INH, AMF_CL_INHERENT, 0, 8'h00, 16'h1000, 0, 0, 0},
        '{AMF_IMM, AMF_CL_ALU, 0, 8'h00, 16'h1234, 1, 1, 0},
        '{AMF_DIR_S, AMF_CL_ALU, 0, 8'h00, 16'h2001, 1, 1, 0},
        '{AMF_DIR_L, AMF_CL_ALU, 0, 8'h00, 16'h3FFF, 2, 2, 0},
        '{AMF_IDX_0, AMF_CL_ALU, 0, 8'h7E, 16'h1100, 0, 0, 0},
        '{AMF_IDX_0, AMF_CL_ALU, 1, 8'hC3, 16'h1200, 1, 0, 0},
        '{AMF_IDX_S, AMF_CL_ALU, 0, 8'hFF, 16'h00C3, 1, 1, 0},
        '{AMF_IDX_S, AMF_CL_ALU, 1, 8'h10, 16'h4455, 2, 1, 0},
        '{AMF_IDX_L, AMF_CL_ALU, 0, 8'hF0, 16'hFFF0, 2, 2, 0},
        '{AMF_IND_S, AMF_CL_ALU, 0, 8'h00, 16'h0500, 1, 2, 0},
        '{AMF_IND_L, AMF_CL_ALU, 0, 8'h00, 16'h06C5, 1, 3, 0},
        '{AMF_INDX_S, AMF_CL_ALU, 0, 8'h80, 16'h0700, 1, 2, 0},
        '{AMF_INDX_L, AMF_CL_ALU, 0, 8'h20, 16'h0810, 1, 3, 0},
        '{AMF_REL_D, AMF_CL_BRANCH, 0, 8'h00, 16'h09B5, 1, 1, 0},
        '{AMF_REL_I, AMF_CL_BRANCH, 0, 8'h00, 16'h0A00, 1, 2, 0},
        '{AMF_BIT_D, AMF_CL_BIT, 0, 8'h00, 16'h0B07, 1, 1, 0},
        '{AMF_BIT_I, AMF_CL_BIT, 0, 8'h00, 16'h0C00, 1, 2, 0},
        '{AMF_BITR_D, AMF_CL_BIT, 0, 8'h00, 16'h0D03, 1, 1, 0},
        '{AMF_BITR_I, AMF_CL_BIT, 0, 8'h00, 16'h0E05, 1, 2, 0},
        '{AMF_IND_S, AMF_CL_RMW, 0, 8'h00, 16'h0F00, 1, 2, 0},
        '{AMF_DIR_L, AMF_CL_RMW, 0, 8'h00, 16'h0F00, 0, 0, 1},
        '{AMF_IND_L, AMF_CL_RMW, 0, 8'h00, 16'h0F00, 0, 0, 1},
        '{AMF_IMM, AMF_CL_RMW, 0, 8'h00, 16'h0F00, 0, 0, 1},
        '{AMF_IDX_L, AMF_CL_JUMP, 0, 8'h05, 16'h1300, 2, 2, 0},
        '{AMF_REL_D, AMF_CL_ALU, 0, 8'h00, 16'h1400, 0, 0, 1},
        '{AMF_INH, AMF_CL_ALU, 0, 8'h00, 16'h1500, 0, 0, 1},
        '{AMF_IDX_S, AMF_CL_INHERENT, 0, 8'h00, 16'h1600, 0, 0, 1}};

    amf_operand_fetch i_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_start(start), .i_mode(mode),
        .i_class(cls), .i_use_y(use_y), .i_bit_sel(bit_sel), .i_x(x), .i_y(y), .i_pc(pc),
        .i_mem_rdata(rdata), .i_mem_rdy(mem_rdy), .o_busy(busy), .o_mem_req(mem_req),
        .o_mem_addr(mem_addr), .o_done(done), .o_illegal(illegal), .o_ea(ea), .o_imm(imm),
        .o_imm_valid(imm_valid), .o_bit_mask(mask), .o_len(len));
    amf_mem_model i_mem (.i_clk(clk), .i_rstn(rstn), .i_req(mem_req), .i_addr(mem_addr),
        .i_slow(slow), .o_rdy(mem_rdy), .o_rdata(rdata));

    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    // pointer word wraps inside page zero
    function automatic logic [15:0] ref_ea(input amf_row_t r);
        logic [7:0]  p;
        logic [15:0] w;
        p = mb(r.pc);
        w = {mb({8'h00, p}), mb({8'h00, p + 8'h01})};
        case (r.m)
            AMF_DIR_S, AMF_BIT_D, AMF_BITR_D: return {8'h00, p};
            AMF_DIR_L:  return {p, mb(r.pc + 16'h0001)};
            AMF_IDX_0:  return {8'h00, r.ix};
            AMF_IDX_S:  return {8'h00, p} + r.ix;
            AMF_IDX_L:  return {p, mb(r.pc + 16'h0001)} + r.ix;
            AMF_IND_S, AMF_BIT_I, AMF_BITR_I: return {8'h00, w[15:8]};
            AMF_IND_L:  return w;
            AMF_INDX_S: return {8'h00, w[15:8]} + r.ix;
            AMF_INDX_L: return w + r.ix;
            AMF_REL_D:  return r.pc + 16'h0001 + {{8{p[7]}}, p};
            default:    return r.pc + 16'h0001 + {{8{w[15]}}, w[15:8]};
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // wrong index register carries the inverse, so a swapped select shows
    task automatic launch(input amf_row_t r);
        mode = r.m;
        cls = r.c;
        use_y = r.y;
        pc = r.pc;
        x = r.y ? ~r.ix : r.ix;
        y = r.y ? r.ix : ~r.ix;
        bit_sel = r.pc[2:0];
        start = 1'b1;
        cyc(1);
        start = 1'b0;
    endtask
    task automatic wait_done();
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        if (done !== 1'b1) begin
            miscompares++;
            $display("[ERR] done expected 1 seen %b", done);
            tally_and_finish();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rstn, start, use_y, slow, bit_sel, x, y, pc} = '0;
        ce = 1'b1;
        mode = AMF_INH;
        cls = AMF_CL_INHERENT;
        cyc(10);
        rstn = 1'b1;
        chk("busy_rst", busy, 1'b0);
        chk("ea_rst", ea, 16'h0000);
        chk("len_rst", len, 2'h0);
        cyc(1);
        foreach (rows[i]) begin
            launch(rows[i]);
            wait_done();
            chk("cycles", n, 1 + rows[i].beats);
            chk("illegal", illegal, rows[i].ill);
            if (!rows[i].ill) chk("len", len, rows[i].len);
            if (!rows[i].ill && rows[i].m > AMF_IMM) chk("ea", ea, ref_ea(rows[i]));
            if (!rows[i].ill && rows[i].m == AMF_IMM) chk("imm", imm, mb(rows[i].pc));
            chk("imm_valid", imm_valid, !rows[i].ill && rows[i].m == AMF_IMM);
            if (rows[i].c == AMF_CL_BIT) chk("mask", mask, 8'h01 << rows[i].pc[2:0]);
            $display("row %0d done", i);
            cyc(1);
        end
        // clock enable low must freeze a fetch and drop the request
        launch(rows[3]);
        chk("addr_op1", mem_addr, rows[3].pc);
        ce = 1'b0;
        cyc(3);
        chk("req_frozen", mem_req, 1'b0);
        chk("busy_frozen", busy, 1'b1);
        ce = 1'b1;
        wait_done();
        chk("ea_ce", ea, ref_ea(rows[3]));
        $display("test ce_freeze done");
        cyc(1);
        // slow memory plus a start while busy, which must be ignored
        slow = 1'b1;
        launch(rows[10]);
        start = 1'b1;
        mode = AMF_INH;
        cls = AMF_CL_INHERENT;
        cyc(1);
        start = 1'b0;
        wait_done();
        chk("ea_slow", ea, ref_ea(rows[10]));
        chk("len_slow", len, 2'h1);
        $display("test slow_busy done");
        cyc(1);
        slow = 1'b0;
        // reset in mid fetch, then recovery
        launch(rows[12]);
        rstn = 1'b0;
        cyc(1);
        chk("busy_midrst", busy, 1'b0);
        chk("ea_midrst", ea, 16'h0000);
        rstn = 1'b1;
        launch(rows[0]);
        wait_done();
        chk("cycles_after_rst", n, 1);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule
